// >>> dv/pbcs_link_partner.sv
// Behavioural far end: cable, partner negotiation and physical layer status.
// Assumes status levels are synchronous to ref_clk.
`timescale 1ns/1ps
module pbcs_link_partner
    import pbcs_pkg::*;
#(
    parameter int AN_CYCLES = 20
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire pbcs_mode_s phyMode,
    input wire logic cableOk,
    input wire logic partnerAn,
    input wire logic partner100,
    input wire logic partnerFull,
    input wire logic rsvdBit,
    output pbcs_phy_s phyStat
);
    int waitCnt;
    logic an;
    assign an = phyMode.autonegEnable;

    // ==========================================================
    // Link drops on cable loss, power-down or restart
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waitCnt <= AN_CYCLES;
            phyStat <= '0;
        end
        else if (!cableOk || phyMode.powerDown || phyMode.autonegRestart)
        begin
            waitCnt <= AN_CYCLES;
            phyStat <= {5'h00, rsvdBit};
        end
        else if (waitCnt != 0)
        begin
            waitCnt <= waitCnt - 1;
            phyStat <= {5'h00, rsvdBit};
        end
        else
            phyStat <= {1'h1, an & partnerAn, an & !partnerAn, partner100, partnerFull, rsvdBit};
    end
endmodule : pbcs_link_partner

// >>> dv/pbcs_regs_bench.sv
// Self-checking bench for the PHY basic control and status registers.
// Assumes the link partner model on phyStat and a 200 MHz clock.
`timescale 1ns/1ps
module pbcs_regs_bench;
    import pbcs_pkg::*;
    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'h0;
    logic regRd = 1'h0;
    logic [15:0] regRdata;
    pbcs_phy_s phyStat;
    pbcs_mode_s phyMode;
    logic irq;
    logic cableOk = 1'h0;
    logic partnerAn = 1'h1;
    logic rsvdBit = 1'h0;
    logic [31:0] seed = 32'h000143CE;
    logic [15:0] expQ[$];
    logic [15:0] base;
    logic [15:0] w;
    bit rdPend = 0;
    int miscompares = 0;
    int checks = 0;

    always #2.5 ref_clk = ~ref_clk;

    pbcs_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .phyStat(phyStat),
        .phyMode(phyMode), .irq(irq));
    pbcs_link_partner #(.AN_CYCLES(20)) u_partner (.ref_clk(ref_clk), .rst_n(rst_n),
        .phyMode(phyMode), .cableOk(cableOk), .partnerAn(partnerAn), .partner100(1'h1),
        .partnerFull(1'h1), .rsvdBit(rsvdBit), .phyStat(phyStat));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic logic [15:0] altOf(input logic [15:0] v);
        return {v[0], v[1], 1'h0, v[2], v[11], v[3], v[4], 1'h0, v[12], v[13], v[8], 5'h00};
    endfunction : altOf

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'h1;
        @(posedge ref_clk);
        regWr <= 1'h0;
        @(posedge ref_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        expQ.push_back(exp);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge ref_clk);
        regRd <= 1'h0;
        @(posedge ref_clk);
    endtask : rd

    // ==========================================================
    // Read data monitor
    always @(posedge ref_clk)
    begin
        if (rdPend)
            chk(regRdata, expQ.pop_front());
        rdPend = regRd && rst_n;
    end

    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    initial
    begin
        #(5 * 20000);
        miscompares++;
        finish_test();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        rsvdBit = 1'(xs());
        base = 16'h7808 | {11'h000, rsvdBit, 4'h0};
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'h1;
        @(posedge ref_clk);
        rd(OFF_CTRL, 16'h1020);
        rd(OFF_STAT, base);
        rd(OFF_ALT_CTRL, 16'h0080);
        rd(OFF_ALT_STAT, 16'h8000 | {7'h00, rsvdBit, 8'h00});
        rd(8'h40, 16'h0000);
        wr(OFF_STAT, 16'h0000);
        rd(OFF_STAT, base);
        $display("test reset done");
        cableOk <= 1'h1;
        repeat (30) @(posedge ref_clk);
        rd(OFF_STAT, base | 16'h0024);
        chk({6'h00, phyMode}, 16'h0390);
        rd(OFF_IRQ_STAT, 16'h0005);
        rd(OFF_IRQ_STAT, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        wr(OFF_IRQ_MASK, 16'h0002);
        cableOk <= 1'h0;
        repeat (3) @(posedge ref_clk);
        chk({15'h0000, irq}, 16'h0001);
        rd(OFF_IRQ_STAT, 16'h0002);
        chk({15'h0000, irq}, 16'h0000);
        cableOk <= 1'h1;
        repeat (30) @(posedge ref_clk);
        wr(OFF_CTRL, 16'h1220);
        rd(OFF_STAT, base);
        $display("test link done");
        for (int i = 0; i < 4; i++)
        begin
            w = 16'h0020 | {2'h0, i[1], 4'h0, i[0], 8'h00};
            wr(OFF_CTRL, w);
            chk({6'h00, phyMode}, {6'h00, i[1], i[0], 8'h10});
            rd(OFF_CTRL, w);
        end
        partnerAn <= 1'h0;
        wr(OFF_CTRL, 16'h1220);
        repeat (30) @(posedge ref_clk);
        chk({6'h00, phyMode}, 16'h0090);
        partnerAn <= 1'h1;
        $display("test forced done");
        repeat (8)
        begin
            w = 16'(xs());
            wr(OFF_CTRL, w);
            rd(OFF_CTRL, w & 16'h793F);
            rd(OFF_ALT_CTRL, altOf(w));
            chk({10'h000, phyMode[5:0]},
                {10'h000, w[11], w[5], w[3] | w[4], w[4], w[1] | w[11], w[0]});
        end
        wr(OFF_ALT_STAT, 16'h0000);
        rd(OFF_CTRL, w & 16'h791F);
        wr(OFF_ALT_CTRL, 16'hFFFF);
        rd(OFF_CTRL, 16'h391F | (w & 16'h4000));
        $display("test random done");
        finish_test();
    end
endmodule : pbcs_regs_bench

// >>> dv/pbcs_regs_chk.sv
// Concurrent checks on the PHY basic control and status register ports.
// Assumes it is bound to pbcs_regs and sees only that module's ports.
`timescale 1ns/1ps
module pbcs_regs_chk
    import pbcs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [PBCS_AW-1:0] regAddr,
    input wire logic [PBCS_DW-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [PBCS_DW-1:0] regRdata,
    input wire pbcs_phy_s phyStat,
    input wire pbcs_mode_s phyMode,
    input wire logic irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // Decoded accesses
    logic ctlWr;
    logic ctlRd;
    logic stRd;
    assign ctlWr = regWr && regAddr == OFF_CTRL;
    assign ctlRd = regRd && regAddr == OFF_CTRL;
    assign stRd = regRd && regAddr == OFF_STAT;

    // ==========================================================
    // Properties
    a_rdata_idle: assert property (!regRd |=> regRdata == 16'h0000)
        else $error("read data not zero outside the read slot");
    a_forced_mode: assert property (ctlWr && !regWdata[12] |=>
        phyMode.speed100 == $past(regWdata[13]) && phyMode.fullDuplex == $past(regWdata[8]))
        else $error("forced speed or duplex not applied");
    a_autoneg_en: assert property (ctlWr |=> phyMode.autonegEnable == $past(regWdata[12]))
        else $error("autoneg enable not applied");
    a_restart_pulse: assert property (ctlWr && regWdata[9] && regWdata[12] |=>
        phyMode.autonegRestart ##1 !phyMode.autonegRestart)
        else $error("restart is not a one cycle pulse");
    a_xover_sel: assert property (ctlWr |=>
        phyMode.crossoverAlgorithmSelect == $past(regWdata[5]) &&
        phyMode.autoCrossoverOff == ($past(regWdata[3]) | $past(regWdata[4])) &&
        phyMode.forceCrossedPairAssignment == $past(regWdata[4]))
        else $error("crossover controls not applied");
    a_tx_power: assert property (ctlWr |=> phyMode.powerDown == $past(regWdata[11]) &&
        phyMode.txDisable == ($past(regWdata[1]) | $past(regWdata[11])))
        else $error("transmit or power-down control not applied");
    a_stat_fixed: assert property (stRd |=> regRdata[15:11] == 5'h0F)
        else $error("capability bits wrong");
    a_stat_caps: assert property (stRd |=> regRdata[3] && !regRdata[0] && !regRdata[1])
        else $error("autoneg capable or extended bit wrong");
    a_stat_live: assert property (stRd |=>
        regRdata[5] == $past(phyStat.autonegDone) && regRdata[2] == $past(phyStat.linkUp))
        else $error("status does not follow the physical layer");
    a_ctrl_unsup: assert property (ctlRd |=> regRdata[15] == 1'h0 && regRdata[10] == 1'h0 &&
        regRdata[9] == 1'h0 && regRdata[7:6] == 2'h0)
        else $error("unsupported control bit reads one");
    a_irq_clear: assert property (regRd && regAddr == OFF_IRQ_STAT && $stable(phyStat.linkUp)
        && !$rose(phyStat.autonegDone) |=> !irq)
        else $error("interrupt still high after the flags were read");
endmodule : pbcs_regs_chk

bind pbcs_regs pbcs_regs_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .phyStat(phyStat), .phyMode(phyMode), .irq(irq));

// >>> verilog/pbcs_irq.sv
// Sticky event flags with mask and one level interrupt output.
// Assumes one-cycle event pulses and a read-to-clear strobe from the register port.
`timescale 1ns/1ps
module pbcs_irq
    import pbcs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [IRQ_W-1:0] eventPulse,
    input wire logic readClear,
    input wire logic maskWr,
    input wire logic [IRQ_W-1:0] maskData,
    output logic [IRQ_W-1:0] flags,
    output logic [IRQ_W-1:0] mask,
    output logic irq
);

    logic [IRQ_W-1:0] next_flags;
    logic [IRQ_W-1:0] next_mask;
    logic next_irq;

    // ==========================================================
    // Next state; a new event wins over the read clear
    always_comb
    begin
        next_flags = (readClear ? '0 : flags) | eventPulse;
        next_mask = maskWr ? maskData : mask;
        next_irq = |(next_flags & next_mask);
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags <= '0;
            mask <= '0;
            irq <= 1'b0;
        end
        else
        begin
            flags <= next_flags;
            mask <= next_mask;
            irq <= next_irq;
        end
    end

endmodule : pbcs_irq

// >>> verilog/pbcs_pkg.sv
// Constants and carrier types for the PHY basic control and status registers.
// Assumes a 16-bit register port with byte offsets and a single 200 MHz clock.
package pbcs_pkg;

    // ==========================================================
    // Register port geometry and offsets
    localparam int PBCS_AW = 8;
    localparam int PBCS_DW = 16;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h02;
    localparam logic [7:0] OFF_ALT_CTRL = 8'h10;
    localparam logic [7:0] OFF_ALT_STAT = 8'h12;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h22;

    // ==========================================================
    // Basic control word bit positions
    localparam int CB_SOFT_RST = 15;
    localparam int CB_RSVD14 = 14;
    localparam int CB_FORCE100 = 13;
    localparam int CB_AUTONEG = 12;
    localparam int CB_PWRDN = 11;
    localparam int CB_ISOLATE = 10;
    localparam int CB_RESTART = 9;
    localparam int CB_FULL = 8;
    localparam int CB_COLTEST = 7;
    localparam int CB_XALG = 5;
    localparam int CB_FORCE_X = 4;
    localparam int CB_NOAUTO_X = 3;
    localparam int CB_RSVD2 = 2;
    localparam int CB_TXOFF = 1;
    localparam int CB_LEDOFF = 0;

    // ==========================================================
    // Basic status word bit positions
    localparam int SB_T4 = 15;
    localparam int SB_CAP_HI = 14;
    localparam int SB_CAP_LO = 11;
    localparam int SB_AN_DONE = 5;
    localparam int SB_RSVD4 = 4;
    localparam int SB_AN_CAP = 3;
    localparam int SB_LINK = 2;
    localparam int SB_EXT = 0;

    // ==========================================================
    // Port control / status bank bit positions (shared storage)
    localparam int AC_LEDOFF = 15;
    localparam int AC_TXOFF = 14;
    localparam int AC_RESTART = 13;
    localparam int AC_RSVD = 12;
    localparam int AC_PWRDN = 11;
    localparam int AC_NOAUTO_X = 10;
    localparam int AC_FORCE_X = 9;
    localparam int AC_AUTONEG = 7;
    localparam int AC_FORCE100 = 6;
    localparam int AC_FULL = 5;
    localparam int AS_XALG = 15;
    localparam int AS_RSVD4 = 8;
    localparam int AS_AN_DONE = 6;
    localparam int AS_LINK = 5;

    // ==========================================================
    // Reset values and interrupt events
    localparam logic RST_AUTONEG = 1'b1;
    localparam logic RST_XALG = 1'b1;
    localparam int IRQ_W = 3;
    localparam int IRQ_LINK_UP = 0;
    localparam int IRQ_LINK_DOWN = 1;
    localparam int IRQ_AN_DONE = 2;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic rsvd14;
        logic force100;
        logic autoneg;
        logic powerDown;
        logic fullDuplex;
        logic crossoverAlgorithmSelect;
        logic forceCrossedPairAssignment;
        logic disableAutoCrossover;
        logic rsvd2;
        logic txDisable;
        logic ledDisable;
    } pbcs_ctrl_s;

    typedef struct packed {
        logic linkUp;
        logic autonegDone;
        logic autonegFailed;
        logic negSpeed100;
        logic negFullDuplex;
        logic rsvdStat4;
    } pbcs_phy_s;

    typedef struct packed {
        logic speed100;
        logic fullDuplex;
        logic autonegEnable;
        logic autonegRestart;
        logic powerDown;
        logic crossoverAlgorithmSelect;
        logic autoCrossoverOff;
        logic forceCrossedPairAssignment;
        logic txDisable;
        logic ledDisable;
    } pbcs_mode_s;

endpackage : pbcs_pkg

// >>> verilog/pbcs_regs.sv
// PHY basic control and status registers with shared port-bank view.
// Assumes a 16-bit strobe register port, read data one cycle after the
// read strobe, and PHY status inputs synchronous to ref_clk.
//
// What this block does
// - Autoneg off: bit 13 picks 100 or 10
// - Bit 12 enables autoneg, resets to one
// - Writing one to bit 9 restarts autoneg when bit 12 is written one
// - Bit 8 picks duplex when autoneg off/failed
// - Bit 5 picks crossover algorithm, resets one
// - Bit 3 stops auto crossover; bit 4 forces crossed
// - Bit 1 disables transmit
// - Status bits 14..11 read one
// - Status bit 15 reads zero
// - Status bit 5 shows autoneg complete
// - Status bit 3 reads one
// - Status bit 0 reads zero
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module pbcs_regs
    import pbcs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [PBCS_AW-1:0] regAddr,
    input wire logic [PBCS_DW-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [PBCS_DW-1:0] regRdata,
    input wire pbcs_phy_s phyStat,
    output pbcs_mode_s phyMode,
    output logic irq
);

    // ==========================================================
    // Word packing shared by decode and readback
    function automatic logic [PBCS_DW-1:0] basicCtrlWord(input pbcs_ctrl_s c);
        logic [PBCS_DW-1:0] w;
        w = '0;
        w[CB_RSVD14] = c.rsvd14;
        w[CB_FORCE100] = c.force100;
        w[CB_AUTONEG] = c.autoneg;
        w[CB_PWRDN] = c.powerDown;
        w[CB_FULL] = c.fullDuplex;
        w[CB_XALG] = c.crossoverAlgorithmSelect;
        w[CB_FORCE_X] = c.forceCrossedPairAssignment;
        w[CB_NOAUTO_X] = c.disableAutoCrossover;
        w[CB_RSVD2] = c.rsvd2;
        w[CB_TXOFF] = c.txDisable;
        w[CB_LEDOFF] = c.ledDisable;
        return w;
    endfunction : basicCtrlWord

    function automatic logic [PBCS_DW-1:0] altCtrlWord(input pbcs_ctrl_s c);
        logic [PBCS_DW-1:0] w;
        w = '0;
        w[AC_LEDOFF] = c.ledDisable;
        w[AC_TXOFF] = c.txDisable;
        w[AC_RSVD] = c.rsvd2;
        w[AC_PWRDN] = c.powerDown;
        w[AC_NOAUTO_X] = c.disableAutoCrossover;
        w[AC_FORCE_X] = c.forceCrossedPairAssignment;
        w[AC_AUTONEG] = c.autoneg;
        w[AC_FORCE100] = c.force100;
        w[AC_FULL] = c.fullDuplex;
        return w;
    endfunction : altCtrlWord

    function automatic pbcs_ctrl_s basicCtrlDecode(input pbcs_ctrl_s c,
                                                  input logic [PBCS_DW-1:0] w);
        pbcs_ctrl_s n;
        n = c;
        n.rsvd14 = w[CB_RSVD14];
        n.force100 = w[CB_FORCE100];
        n.autoneg = w[CB_AUTONEG];
        n.powerDown = w[CB_PWRDN];
        n.fullDuplex = w[CB_FULL];
        n.crossoverAlgorithmSelect = w[CB_XALG];
        n.forceCrossedPairAssignment = w[CB_FORCE_X];
        n.disableAutoCrossover = w[CB_NOAUTO_X];
        n.rsvd2 = w[CB_RSVD2];
        n.txDisable = w[CB_TXOFF];
        n.ledDisable = w[CB_LEDOFF];
        return n;
    endfunction : basicCtrlDecode

    function automatic pbcs_ctrl_s altCtrlDecode(input pbcs_ctrl_s c,
                                                input logic [PBCS_DW-1:0] w);
        pbcs_ctrl_s n;
        n = c;
        n.ledDisable = w[AC_LEDOFF];
        n.txDisable = w[AC_TXOFF];
        n.rsvd2 = w[AC_RSVD];
        n.powerDown = w[AC_PWRDN];
        n.disableAutoCrossover = w[AC_NOAUTO_X];
        n.forceCrossedPairAssignment = w[AC_FORCE_X];
        n.autoneg = w[AC_AUTONEG];
        n.force100 = w[AC_FORCE100];
        n.fullDuplex = w[AC_FULL];
        return n;
    endfunction : altCtrlDecode

    localparam pbcs_ctrl_s CTRL_RESET = '{
        rsvd14: 1'b0,
        force100: 1'b0,
        autoneg: RST_AUTONEG,
        powerDown: 1'b0,
        fullDuplex: 1'b0,
        crossoverAlgorithmSelect: RST_XALG,
        forceCrossedPairAssignment: 1'b0,
        disableAutoCrossover: 1'b0,
        rsvd2: 1'b0,
        txDisable: 1'b0,
        ledDisable: 1'b0
    };

    // ==========================================================
    // State
    pbcs_ctrl_s ctrl;
    pbcs_ctrl_s next_ctrl;
    pbcs_mode_s next_phyMode;
    logic [PBCS_DW-1:0] next_regRdata;
    logic prevLinkUp;
    logic prevAnDone;
    logic restartReq;
    logic [IRQ_W-1:0] events;
    logic [IRQ_W-1:0] irqFlags;
    logic [IRQ_W-1:0] irqMask;
    logic [PBCS_DW-1:0] basicStat;
    logic [PBCS_DW-1:0] altStat;
    logic hitCtrl;
    logic hitAltCtrl;
    logic hitAltStat;

    // ==========================================================
    // Address decode
    assign hitCtrl = regWr && (regAddr == OFF_CTRL);
    assign hitAltCtrl = regWr && (regAddr == OFF_ALT_CTRL);
    assign hitAltStat = regWr && (regAddr == OFF_ALT_STAT);

    // ==========================================================
    // Status words
    always_comb
    begin
        basicStat = '0;
        basicStat[SB_T4] = 1'b0;
        basicStat[SB_CAP_HI:SB_CAP_LO] = '1;
        basicStat[SB_AN_DONE] = phyStat.autonegDone;
        basicStat[SB_RSVD4] = phyStat.rsvdStat4;
        basicStat[SB_AN_CAP] = 1'b1;
        basicStat[SB_LINK] = phyStat.linkUp;
        basicStat[SB_EXT] = 1'b0;
        altStat = '0;
        altStat[AS_XALG] = ctrl.crossoverAlgorithmSelect;
        altStat[AS_RSVD4] = phyStat.rsvdStat4;
        altStat[AS_AN_DONE] = phyStat.autonegDone;
        altStat[AS_LINK] = phyStat.linkUp;
    end

    // ==========================================================
    // Control storage and restart request
    always_comb
    begin
        next_ctrl = ctrl;
        restartReq = 1'b0;
        if (hitCtrl)
        begin
            next_ctrl = basicCtrlDecode(ctrl, regWdata);
            restartReq = regWdata[CB_RESTART];
        end
        if (hitAltCtrl)
        begin
            next_ctrl = altCtrlDecode(ctrl, regWdata);
            restartReq = regWdata[AC_RESTART];
        end
        if (hitAltStat)
        begin
            next_ctrl.crossoverAlgorithmSelect = regWdata[AS_XALG];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl <= CTRL_RESET;
        end
        else
        begin
            ctrl <= next_ctrl;
        end
    end

    // ==========================================================
    // Read data, zero outside the read slot
    always_comb
    begin
        next_regRdata = '0;
        if (regRd)
        begin
            unique case (regAddr)
                OFF_CTRL: next_regRdata = basicCtrlWord(ctrl);
                OFF_STAT: next_regRdata = basicStat;
                OFF_ALT_CTRL: next_regRdata = altCtrlWord(ctrl);
                OFF_ALT_STAT: next_regRdata = altStat;
                OFF_IRQ_STAT: next_regRdata = {{(PBCS_DW-IRQ_W){1'b0}}, irqFlags};
                OFF_IRQ_MASK: next_regRdata = {{(PBCS_DW-IRQ_W){1'b0}}, irqMask};
                default: next_regRdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            regRdata <= '0;
        end
        else
        begin
            regRdata <= next_regRdata;
        end
    end

    // ==========================================================
    // Operating mode driven to the PHY
    always_comb
    begin
        next_phyMode.autonegEnable = next_ctrl.autoneg;
        next_phyMode.autonegRestart = restartReq && next_ctrl.autoneg;
        if (next_ctrl.autoneg && phyStat.autonegDone)
        begin
            next_phyMode.speed100 = phyStat.negSpeed100;
        end
        else
        begin
            next_phyMode.speed100 = next_ctrl.force100;
        end
        if (!next_ctrl.autoneg || phyStat.autonegFailed)
        begin
            next_phyMode.fullDuplex = next_ctrl.fullDuplex;
        end
        else
        begin
            next_phyMode.fullDuplex = phyStat.negFullDuplex;
        end
        next_phyMode.powerDown = next_ctrl.powerDown;
        next_phyMode.crossoverAlgorithmSelect = next_ctrl.crossoverAlgorithmSelect;
        next_phyMode.autoCrossoverOff = next_ctrl.disableAutoCrossover
                                        || next_ctrl.forceCrossedPairAssignment;
        next_phyMode.forceCrossedPairAssignment = next_ctrl.forceCrossedPairAssignment;
        next_phyMode.txDisable = next_ctrl.txDisable || next_ctrl.powerDown;
        next_phyMode.ledDisable = next_ctrl.ledDisable;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phyMode <= '0;
        end
        else
        begin
            phyMode <= next_phyMode;
        end
    end

    // ==========================================================
    // Link and negotiation events
    always_comb
    begin
        events = '0;
        events[IRQ_LINK_UP] = phyStat.linkUp && !prevLinkUp;
        events[IRQ_LINK_DOWN] = !phyStat.linkUp && prevLinkUp;
        events[IRQ_AN_DONE] = phyStat.autonegDone && !prevAnDone;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prevLinkUp <= 1'b0;
            prevAnDone <= 1'b0;
        end
        else
        begin
            prevLinkUp <= phyStat.linkUp;
            prevAnDone <= phyStat.autonegDone;
        end
    end

    // ==========================================================
    // Interrupt flags
    pbcs_irq u_irq (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .eventPulse(events),
        .readClear(regRd && (regAddr == OFF_IRQ_STAT)),
        .maskWr(regWr && (regAddr == OFF_IRQ_MASK)),
        .maskData(regWdata[IRQ_W-1:0]),
        .flags(irqFlags),
        .mask(irqMask),
        .irq(irq)
    );

endmodule : pbcs_regs
